// File: core/fsp_consts.svh
// Purpose: Shared opcodes, counts, reset values and timing
// Assumes: 10 MHz system clock
// Notes: Time figures in ns, cycle counts derived from them
`ifndef FSP_CONSTS_SVH
`define FSP_CONSTS_SVH

// Opcodes
`define FSP_OP_WLSET 8'h06
`define FSP_OP_WLCLR 8'h04
`define FSP_OP_SREAD 8'h05
`define FSP_OP_SWRITE 8'h01
`define FSP_OP_IDREAD 8'h9f
`define FSP_OP_QREAD 8'heb
`define FSP_OP_QWREAD 8'he7
`define FSP_OP_QPROG 8'h38

// Bit counts within a frame
`define FSP_OP_BITS 6'h08
`define FSP_SW_BITS 6'h10
`define FSP_ID_END 6'h20
`define FSP_RING_TOP 6'h28
`define FSP_RING_BACK 6'h08

// Non-volatile status reset value: lock, quad enable, protect level
`define FSP_NV_RST 6'h00

// Status write cycle time
`define FSP_CLK_NS 100
`define FSP_SW_TIME_NS 40000
`define FSP_SW_CYC ((`FSP_SW_TIME_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)

`endif

// File: core/fsp_pkg.sv
// Purpose: Types shared by the status and protection logic
// Assumes: Nothing
// Notes: Status struct follows the status byte bit order
package fsp_pkg;

    typedef struct packed {
        logic lock;
        logic quad_io_enable;
        logic [3:0] bp;
        logic latch;
        logic busy;
    } fsp_stat_t;

    typedef struct packed {
        logic start;
        logic chip;
        logic prot_hit;
        logic busy;
        logic done;
    } fsp_pe_t;

    typedef enum logic {ST_IDLE, ST_SWR} fsp_state_t;

endpackage

// File: core/fsp_sync.sv
// Purpose: Two-flop level synchroniser
// Assumes: Each bit is an independent level
// Notes: First stage is read only by the second
`timescale 1ns/1ps
module fsp_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_r <= '0;
            q <= '0;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// File: core/fsp_status_core.sv
// Purpose: Status register, write protection and identity read of a serial flash
// Assumes: Link logic on the serial clock, register logic on clk; mode settled 300 ns before a frame
// Notes: Frame results are read in clk domain only after chip select is seen high
//
// Overview of operation
// - Identity read sends maker byte, two part bytes
// - Identity read ignored while array busy
// - Chip select high returns to standby
// - Status read accepted at all times
// - Opcode: eight serial or two quad clocks
// - Status read 05, status write 01
// - Bit 0 busy during any cycle
// - Write latch gates program, erase, status write
// - Protected region program or erase ignored
// - Bits 5:2 protect level, status write only
// - Chip erase only with protect level zero
// - Bit 6 quad enable frees line two
// - Serial quad commands invalid without quad enable
// - Quad enable ignored in quad command mode
// - Lock plus low pin refuses status writes
// - Status write needs prior write latch set
// - Status write sets level, quad, lock only
// - Chip select must rise on byte boundary
// - Cycle starts at rise, ends clearing latch
// - Opcode 06 sets write latch
// - Quad mode or quad enable disables pin protection
`timescale 1ns/1ps
`include "fsp_consts.svh"
module fsp_status_core #(
    parameter logic [7:0] MAKER_CODE = 8'h5a,
    parameter logic [15:0] PART_CODE = 16'ha5c3,
    parameter logic [7:0] ID_READ_OP = `FSP_OP_IDREAD,
    parameter int SW_CYC = `FSP_SW_CYC
) (
    // System
    input wire logic clk,
    input wire logic rst,
    // Serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic [3:0] sio_in,
    output logic [3:0] sio_out,
    output logic [3:0] sio_oe_n,
    // Mode
    input wire logic quad_command_mode,
    // Array engine
    input wire fsp_pkg::fsp_pe_t pe_req,
    output logic pe_accept,
    // Status and command report
    output fsp_pkg::fsp_stat_t flash_status,
    output logic hard_protect_mode,
    output logic cmd_done,
    output logic [7:0] cmd_op,
    output logic cmd_valid
);
    // Maker code and part code values are arbitrary
    localparam logic [23:0] ID_WORD = {MAKER_CODE, PART_CODE};
    localparam logic [15:0] SW_LAST = 16'(SW_CYC - 1);

    function automatic logic [7:0] shift_in(input logic [7:0] cur, input logic [3:0] sio,
                                            input logic quad);
        shift_in = quad ? {cur[3:0], sio} : {cur[6:0], sio[0]};
    endfunction

    // Link domain
    logic frame_rst;
    logic [5:0] cnt_r;
    logic [5:0] cnt_nxt;
    logic [7:0] op_r;
    logic [7:0] op_nxt;
    logic [7:0] dat_r;
    logic [7:0] dat_nxt;
    logic [5:0] lf_cnt_r;
    logic [7:0] lf_op_r;
    logic [7:0] lf_dat_r;
    logic [3:0] out_r;
    logic [3:0] oe_r;
    logic [7:0] to_link;
    logic [7:0] at_link;
    fsp_pkg::fsp_stat_t stat_l;
    logic quad_l;
    logic [5:0] sel;
    logic [23:0] id_sh;
    logic [7:0] st_sh;
    logic rd_stat;
    logic rd_id;
    logic [3:0] nib;

    // Clock domain
    logic [1:0] pin_s;
    logic cs_s;
    logic wp_s;
    logic cs_d_r;
    logic cs_rise;
    fsp_pkg::fsp_state_t state_r;
    fsp_pkg::fsp_state_t state_nxt;
    logic [15:0] tmr_r;
    logic [7:0] sw_dat_r;
    logic [5:0] nv_r;
    logic latch_r;
    logic busy_r;
    logic hard_prot;
    logic quad_r;
    logic sw_done;
    logic wl_set_hit;
    logic wl_clr_hit;
    logic sw_hit;
    logic quad_op;

    assign frame_rst = rst | cs_n;

    // Status carried into the link domain as independent levels
    assign to_link = flash_status;

    fsp_sync #(.W(8)) u_link_sync (
        .clk(sclk),
        .rst(rst),
        .d(to_link),
        .q(at_link)
    );

    // Mode register moves only between frames, so the link reads it from the first edge
    assign quad_l = quad_r;
    assign stat_l = at_link;

    // Bit counting and opcode capture
    always_comb
    begin
        op_nxt = op_r;
        dat_nxt = dat_r;
        if (cnt_r < `FSP_OP_BITS)
        begin
            op_nxt = shift_in(op_r, sio_in, quad_l);
        end
        else if (cnt_r < `FSP_SW_BITS)
        begin
            dat_nxt = shift_in(dat_r, sio_in, quad_l);
        end
        cnt_nxt = cnt_r + (quad_l ? 6'h04 : 6'h01);
        if (cnt_nxt >= `FSP_RING_TOP)
        begin
            cnt_nxt = cnt_nxt - `FSP_RING_BACK;
        end
    end

    // Chip select high clears the frame state: standby
    always_ff @(posedge sclk or posedge frame_rst)
    begin
        if (frame_rst)
        begin
            cnt_r <= 6'h00;
            op_r <= 8'h00;
            dat_r <= 8'h00;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            op_r <= op_nxt;
            dat_r <= dat_nxt;
        end
    end

    // Last frame result, stable while chip select is high
    always_ff @(posedge sclk or posedge rst)
    begin
        if (rst)
        begin
            lf_cnt_r <= 6'h00;
            lf_op_r <= 8'h00;
            lf_dat_r <= 8'h00;
        end
        else
        begin
            lf_cnt_r <= cnt_nxt;
            lf_op_r <= op_nxt;
            lf_dat_r <= dat_nxt;
        end
    end

    // Output selection
    always_comb
    begin
        sel = cnt_r - `FSP_OP_BITS;
        id_sh = ID_WORD << sel;
        st_sh = stat_l << sel[2:0];
        rd_stat = (cnt_r >= `FSP_OP_BITS) && (op_r == `FSP_OP_SREAD);
        rd_id = (cnt_r >= `FSP_OP_BITS) && (cnt_r < `FSP_ID_END) && (op_r == ID_READ_OP)
            && !stat_l.busy;
        nib = rd_id ? id_sh[23:20] : st_sh[7:4];
    end

    // Data shifts out on the falling edge
    always_ff @(negedge sclk or posedge frame_rst)
    begin
        if (frame_rst)
        begin
            out_r <= 4'h0;
            oe_r <= 4'h0;
        end
        else
        begin
            out_r <= quad_l ? nib : {2'h0, nib[3], 1'h0};
            if (rd_stat || rd_id)
            begin
                oe_r <= quad_l ? 4'hf : 4'h2;
            end
            else
            begin
                oe_r <= 4'h0;
            end
        end
    end

    assign sio_out = out_r;
    assign sio_oe_n = ~oe_r;

    // Chip select and write protect pin into the clock domain
    fsp_sync #(.W(2)) u_pin_sync (
        .clk(clk),
        .rst(rst),
        .d({~cs_n, sio_in[2]}),
        .q(pin_s)
    );

    // Inverted on the way in, so reset leaves the idle level and no false rise
    assign cs_s = !pin_s[1];
    assign wp_s = pin_s[0];

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cs_d_r <= 1'h1;
        end
        else
        begin
            cs_d_r <= cs_s;
        end
    end

    assign cs_rise = cs_s && !cs_d_r;

    // Mode is taken only while no frame runs and holds through the next one
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            quad_r <= 1'h0;
        end
        else if (cs_s && cs_d_r)
        begin
            quad_r <= quad_command_mode;
        end
    end

    // Protection and command decode at end of frame
    assign hard_prot = nv_r[5] && !wp_s && !quad_command_mode && !nv_r[4];
    assign wl_set_hit = cs_rise && (lf_op_r == `FSP_OP_WLSET) && (lf_cnt_r == `FSP_OP_BITS)
        && !busy_r;
    assign wl_clr_hit = cs_rise && (lf_op_r == `FSP_OP_WLCLR) && (lf_cnt_r == `FSP_OP_BITS)
        && !busy_r;
    assign sw_hit = cs_rise && (lf_op_r == `FSP_OP_SWRITE) && (lf_cnt_r == `FSP_SW_BITS)
        && latch_r && !busy_r && !hard_prot;
    assign sw_done = (state_r == fsp_pkg::ST_SWR) && (tmr_r == SW_LAST);
    assign quad_op = (lf_op_r == `FSP_OP_QREAD) || (lf_op_r == `FSP_OP_QWREAD)
        || (lf_op_r == `FSP_OP_QPROG);

    // Status write cycle sequencing
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            fsp_pkg::ST_IDLE:
            begin
                if (sw_hit)
                begin
                    state_nxt = fsp_pkg::ST_SWR;
                end
            end
            fsp_pkg::ST_SWR:
            begin
                if (sw_done)
                begin
                    state_nxt = fsp_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_r <= fsp_pkg::ST_IDLE;
            tmr_r <= 16'h0000;
            sw_dat_r <= 8'h00;
        end
        else
        begin
            state_r <= state_nxt;
            if (sw_hit)
            begin
                tmr_r <= 16'h0000;
                sw_dat_r <= lf_dat_r;
            end
            else if (state_r == fsp_pkg::ST_SWR)
            begin
                tmr_r <= tmr_r + 16'h0001;
            end
        end
    end

    // Non-volatile bits change only at the end of a status write
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            nv_r <= `FSP_NV_RST;
        end
        else if (sw_done)
        begin
            nv_r <= sw_dat_r[7:2];
        end
    end

    // Write latch
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            latch_r <= 1'h0;
        end
        else if (wl_set_hit)
        begin
            latch_r <= 1'h1;
        end
        else if (wl_clr_hit || sw_done || pe_req.done)
        begin
            latch_r <= 1'h0;
        end
    end

    // Busy follows the status write cycle and the array engine
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            busy_r <= 1'h0;
        end
        else
        begin
            busy_r <= (state_nxt == fsp_pkg::ST_SWR) || pe_req.busy;
        end
    end

    // Command report
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cmd_done <= 1'h0;
            cmd_op <= 8'h00;
            cmd_valid <= 1'h0;
        end
        else
        begin
            cmd_done <= cs_rise && (lf_cnt_r >= `FSP_OP_BITS);
            if (cs_rise && (lf_cnt_r >= `FSP_OP_BITS))
            begin
                cmd_op <= lf_op_r;
                cmd_valid <= !(quad_op && !quad_command_mode && !nv_r[4]);
            end
        end
    end

    assign pe_accept = pe_req.start && latch_r && !busy_r && !pe_req.prot_hit
        && (!pe_req.chip || (nv_r[3:0] == 4'h0));
    assign flash_status = {nv_r, latch_r, busy_r};
    assign hard_protect_mode = hard_prot;

    busy_cycle_a: assert property (@(posedge clk) disable iff (rst)
        (state_r == fsp_pkg::ST_SWR) |-> busy_r)
        else $error("busy flag low during status write");

    cycle_length_a: assert property (@(posedge clk) disable iff (rst)
        $fell(state_r == fsp_pkg::ST_SWR) |-> ($past(tmr_r) == SW_LAST))
        else $error("status write cycle length wrong");

    latch_end_a: assert property (@(posedge clk) disable iff (rst)
        $fell(state_r == fsp_pkg::ST_SWR) |-> !latch_r && !busy_r)
        else $error("latch or busy left set after status write");

    nv_hold_a: assert property (@(posedge clk) disable iff (rst)
        (state_r == fsp_pkg::ST_IDLE) |=> $stable(nv_r))
        else $error("protect bits changed outside status write");

    hard_refuse_a: assert property (@(posedge clk) disable iff (rst)
        (cs_rise && hard_prot && state_r == fsp_pkg::ST_IDLE) |=> (state_r == fsp_pkg::ST_IDLE))
        else $error("status write run in hardware protection");

    need_latch_a: assert property (@(posedge clk) disable iff (rst)
        (cs_rise && !latch_r && state_r == fsp_pkg::ST_IDLE) |=> (state_r == fsp_pkg::ST_IDLE))
        else $error("status write run without write latch");

    byte_bound_a: assert property (@(posedge clk) disable iff (rst)
        (cs_rise && lf_cnt_r != `FSP_SW_BITS && state_r == fsp_pkg::ST_IDLE)
        |=> (state_r == fsp_pkg::ST_IDLE))
        else $error("status write run off byte boundary");

    latch_set_a: assert property (@(posedge clk) disable iff (rst)
        wl_set_hit |=> latch_r ##1 (latch_r || busy_r || $past(pe_req.done)))
        else $error("write latch not set by set command");

    chip_erase_a: assert property (@(posedge clk) disable iff (rst)
        (pe_accept && pe_req.chip) |-> (flash_status.bp == 4'h0))
        else $error("chip erase accepted with protect level set");

    pe_gate_a: assert property (@(posedge clk) disable iff (rst)
        pe_accept |-> latch_r && !busy_r && !pe_req.prot_hit)
        else $error("program or erase accepted while refused");
endmodule

// File: bench/fsp_host.sv
// Purpose: Host serial controller model for the flash status link
// Assumes: Link clock of 125 ns, running only inside frames
// Notes: Released data lines show the inverse of their last value
`timescale 1ns/1ps
module fsp_host (
    // Link
    output logic sclk,
    output logic cs_n,
    output logic [3:0] sio_in,
    input wire logic [3:0] sio_out,
    input wire logic [3:0] sio_oe_n,
    // Mode and protect pin
    input wire logic quad,
    input wire logic wp_n
);
    logic [3:0] d = 4'h5;
    logic drove = 1'b0;
    logic [3:0] line;
    // Released lines read as the inverse of the value last put out
    assign line = sio_out ^ sio_oe_n;
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
    end
    // Line two is the protect pin unless in quad command mode
    assign sio_in = {d[3], quad ? d[2] : wp_n, d[1:0]};
    // One frame: opcode, one data byte, then zeros; nbits in total
    task automatic xfer(input logic [7:0] op, input logic [7:0] dat, input int nbits,
        output logic [31:0] rd);
        logic [31:0] tx;
        int w;
        tx = {op, dat, 16'h0000};
        w = quad ? 4 : 1;
        rd = 32'h0;
        drove = 1'b0;
        cs_n = 1'b0;
        for (int i = 0; i < nbits / w; i++)
        begin
            if (quad)
                d = tx[31 - 4 * i -: 4];
            else
                d = {~d[3], ~d[2], ~d[1], tx[31 - i]};
            #62.5 sclk = 1'b1;
            if (i * w >= 8)
                rd = quad ? {rd[27:0], line} : {rd[30:0], line[1]};
            drove = drove | (sio_oe_n != 4'hf);
            #62.5 sclk = 1'b0;
        end
        #62.5 cs_n = 1'b1;
        d = ~d;
        #500;
    endtask
endmodule

// File: bench/test_fsp_status_core.sv
// Purpose: Self-checking bench for the flash status and protection logic
// Assumes: Short status write cycle of 40 clocks
// Notes: Frames come from the host model, clk inputs are driven here
`timescale 1ns/1ps
module test_fsp_status_core;
    localparam logic [7:0] MAKER = 8'h3e; // Arbitrary value
    localparam logic [15:0] PART = 16'h71b4; // Arbitrary value
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sclk;
    logic cs_n;
    logic [3:0] sio_in;
    logic [3:0] sio_out;
    logic [3:0] sio_oe_n;
    logic qmode = 1'b0;
    logic wp_n = 1'b1;
    fsp_pkg::fsp_pe_t pe_req = '0;
    logic pe_accept;
    fsp_pkg::fsp_stat_t flash_status;
    logic hard_protect_mode;
    logic cmd_done;
    logic [7:0] cmd_op;
    logic cmd_valid;
    logic [31:0] rd;
    logic [7:0] qops [3] = '{8'heb, 8'he7, 8'h38};
    int n_fail = 0;
    int cmp_count = 0;
    int n_done = 0;
    int d0;

    always #50 clk = ~clk;

    // Frame reports, counted away from the launching edge
    always @(negedge clk)
    begin
        if (cmd_done === 1'b1)
            n_done++;
    end

    fsp_status_core #(.MAKER_CODE(MAKER), .PART_CODE(PART), .SW_CYC(40)) i_dut (
        .clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sio_in(sio_in),
        .sio_out(sio_out), .sio_oe_n(sio_oe_n), .quad_command_mode(qmode),
        .pe_req(pe_req), .pe_accept(pe_accept), .flash_status(flash_status),
        .hard_protect_mode(hard_protect_mode), .cmd_done(cmd_done), .cmd_op(cmd_op),
        .cmd_valid(cmd_valid));

    fsp_host i_host (.sclk(sclk), .cs_n(cs_n), .sio_in(sio_in), .sio_out(sio_out),
        .sio_oe_n(sio_oe_n), .quad(qmode), .wp_n(wp_n));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        if (n_fail == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic xf(input logic [7:0] op, input logic [7:0] dat, input int nb);
        i_host.xfer(op, dat, nb, rd);
    endtask

    task automatic status_read_cmd;
        xf(8'h05, 8'h00, 16);
    endtask

    // Poll busy until clear, bounded
    task automatic wait_idle;
        int k;
        for (k = 0; k < 20; k++)
        begin
            status_read_cmd();
            if (rd[0] === 1'b0)
                break;
        end
        if (k == 20)
        begin
            n_fail++;
            wrap_up();
        end
        else
        begin
            // A poll may straddle the change, so read once more
            status_read_cmd();
        end
    endtask

    task automatic status_write_cmd(input logic [7:0] v);
        xf(8'h06, 8'h00, 8);
        xf(8'h01, v, 16);
        wait_idle();
    endtask

    task automatic pe_try(input logic chip, input logic hit, input logic exp);
        tick(1);
        pe_req = '{start: 1'b1, chip: chip, prot_hit: hit, default: 1'b0};
        #1 chk(32'(pe_accept), 32'(exp));
        tick(1);
        pe_req = '0;
    endtask

    initial
    begin
        tick(5);
        rst = 1'b0;
        tick(3);
        chk(32'(flash_status), 32'h0);
        chk(32'(sio_oe_n), 32'hf);
        status_read_cmd();
        chk(rd, 32'h0);
        xf(8'h01, 8'h3c, 16);
        tick(50);
        chk(32'(flash_status), 32'h0);
        xf(8'h06, 8'h00, 8);
        chk(32'(flash_status), 32'h2);
        xf(8'h01, 8'h3c, 15);
        tick(50);
        status_read_cmd();
        chk(rd, 32'h2);
        xf(8'h01, 8'hff, 16);
        tick(4);
        chk(32'(flash_status), 32'h3);
        status_read_cmd();
        chk(rd, 32'h3);
        wait_idle();
        chk(rd, 32'hfc);
        xf(8'h05, 8'h00, 32);
        chk(rd, 32'hfcfcfc);
        wp_n = 1'b0;
        tick(4);
        chk(32'(hard_protect_mode), 32'h0);
        status_write_cmd(8'h80);
        chk(rd, 32'h80);
        chk(32'(hard_protect_mode), 32'h1);
        xf(8'h06, 8'h00, 8);
        xf(8'h01, 8'h00, 16);
        tick(50);
        status_read_cmd();
        chk(rd & 32'hfc, 32'h80);
        tick(1);
        qmode = 1'b1;
        tick(4);
        chk(32'(hard_protect_mode), 32'h0);
        status_read_cmd();
        chk(rd & 32'hfc, 32'h80);
        status_write_cmd(8'h00);
        chk(rd, 32'h0);
        xf(8'heb, 8'h00, 8);
        chk(32'(cmd_valid), 32'h1);
        tick(1);
        qmode = 1'b0;
        wp_n = 1'b1;
        tick(4);
        d0 = n_done;
        foreach (qops[j])
        begin
            xf(qops[j], 8'h00, 8);
            chk(32'({cmd_op, cmd_valid}), {23'h0, qops[j], 1'b0});
        end
        xf(8'h06, 8'h00, 8);
        chk(32'({cmd_op, cmd_valid}), 32'h0d);
        chk(32'(n_done - d0), 32'h4);
        pe_try(1'b1, 1'b0, 1'b1);
        pe_try(1'b0, 1'b1, 1'b0);
        status_write_cmd(8'h04);
        xf(8'h06, 8'h00, 8);
        pe_try(1'b1, 1'b0, 1'b0);
        pe_try(1'b0, 1'b0, 1'b1);
        xf(8'h04, 8'h00, 8);
        pe_try(1'b0, 1'b0, 1'b0);
        tick(1);
        pe_req.busy = 1'b1;
        tick(3);
        chk(32'(flash_status.busy), 32'h1);
        xf(8'h9f, 8'h00, 32);
        chk(32'(i_host.drove), 32'h0);
        tick(1);
        pe_req.busy = 1'b0;
        tick(3);
        xf(8'h9f, 8'h00, 32);
        chk(rd, {8'h00, MAKER, PART});
        xf(8'h9f, 8'h00, 20);
        chk(32'(sio_oe_n), 32'hf);
        wrap_up();
    end
endmodule
